// File: dv/sbl_sram_host_chk.sv
// Pin-level assertions for the SRAM host port.
// Bound into sbl_sram_host; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module sbl_sram_host_chk #(
	parameter int AW = 18,
	parameter int DW = 16
) (
	// Clock and reset
	input  wire logic          SYS_CLK,
	input  wire logic          RST,
	// User side
	input  wire logic          REQ_VALID,
	input  wire logic          REQ_READY,
	input  wire logic          REQ_WRITE,
	input  wire logic [1:0]    REQ_BYTE_EN,
	input  wire logic          RSP_VALID,
	// Memory pins
	input  wire logic [AW-1:0] SRAM_ADDR,
	input  wire logic          SRAM_CS_N,
	input  wire logic          SRAM_OE_N,
	input  wire logic          SRAM_WE_N,
	input  wire logic          SRAM_LOW_BYTE_LANE_SEL_N,
	input  wire logic          SRAM_HIGH_BYTE_LANE_SEL_N,
	input  wire logic [DW-1:0] SRAM_DQ_O,
	input  wire logic [1:0]    SRAM_DQ_OE
);
	logic [1:0] sel;
	logic       tk;
	assign sel = ~{SRAM_HIGH_BYTE_LANE_SEL_N, SRAM_LOW_BYTE_LANE_SEL_N};
	assign tk = REQ_VALID && REQ_READY && REQ_BYTE_EN != 2'h0;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	a_read_answer: assert property (tk && !REQ_WRITE |-> ##[3:4] RSP_VALID)
		else $error("read answer not in time");
	a_write_answer: assert property (tk && REQ_WRITE |-> ##[4:5] RSP_VALID)
		else $error("write answer not in time");
	a_strobe_in_read: assert property (!SRAM_WE_N |-> SRAM_OE_N)
		else $error("strobe low with output drive on");
	a_write_window: assert property ($fell(SRAM_WE_N) |-> !SRAM_CS_N
		&& sel != 2'h0 && SRAM_DQ_OE == sel)
		else $error("strobe fell outside a write window");
	a_data_held: assert property ($rose(SRAM_WE_N) |-> $stable(SRAM_DQ_O)
		&& SRAM_DQ_OE == $past(SRAM_DQ_OE))
		else $error("data moved at strobe rise");
	a_strobe_ends: assert property ($rose(SRAM_WE_N) |-> !SRAM_CS_N)
		else $error("select left before strobe");
	a_lane_drive: assert property ((SRAM_DQ_OE & ~sel) == 2'h0)
		else $error("driving an unselected lane");
	a_no_contend: assert property (SRAM_DQ_OE != 2'h0 |-> SRAM_OE_N)
		else $error("host drives while memory drives");
	a_addr_stable: assert property (!SRAM_CS_N && !$past(SRAM_CS_N)
		|-> $stable(SRAM_ADDR))
		else $error("address moved while selected");
	a_release_first: assert property ($fell(SRAM_OE_N)
		|-> $past(SRAM_DQ_OE) == 2'h0)
		else $error("bus not released before read");
endmodule : sbl_sram_host_chk
bind sbl_sram_host sbl_sram_host_chk #(.AW(AW), .DW(DW)) u_chk (
	.SYS_CLK(SYS_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
	.REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE),
	.REQ_BYTE_EN(REQ_BYTE_EN), .RSP_VALID(RSP_VALID),
	.SRAM_ADDR(SRAM_ADDR), .SRAM_CS_N(SRAM_CS_N), .SRAM_OE_N(SRAM_OE_N),
	.SRAM_WE_N(SRAM_WE_N), .SRAM_DQ_O(SRAM_DQ_O), .SRAM_DQ_OE(SRAM_DQ_OE),
	.SRAM_LOW_BYTE_LANE_SEL_N(SRAM_LOW_BYTE_LANE_SEL_N),
	.SRAM_HIGH_BYTE_LANE_SEL_N(SRAM_HIGH_BYTE_LANE_SEL_N));
`default_nettype wire

// File: dv/sbl_sram_model.sv
// Behavioural 256K x 16 byte-lane static memory.
// Resolves the shared data bus from host and memory drivers.
`timescale 1ns/100ps
`default_nettype none
module sbl_sram_model (
	// Control pins
	input  wire logic [17:0] addr,
	input  wire logic        cs_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        low_byte_lane_sel_n,
	input  wire logic        high_byte_lane_sel_n,
	// Host data drivers
	input  wire logic [15:0] host_dq,
	input  wire logic [1:0]  host_oe,
	// Resolved bus
	output logic      [15:0] bus
);
	logic [15:0] mem [logic [17:0]];
	logic [15:0] word;
	logic [15:0] last = 16'h0000;
	logic [1:0]  sel;
	logic [1:0]  drv;
	assign sel = ~{high_byte_lane_sel_n, low_byte_lane_sel_n} & {2{~cs_n}};
	assign drv = (!oe_n && we_n) ? sel : 2'h0;
	// Released lanes show the inverse of the last word the memory drove
	assign bus[7:0] = host_oe[0] ? host_dq[7:0]
		: drv[0] ? word[7:0] : ~last[7:0];
	assign bus[15:8] = host_oe[1] ? host_dq[15:8]
		: drv[1] ? word[15:8] : ~last[15:8];
	always @(drv or word) begin
		if (drv != 2'h0)
			last = word;
	end
	always @(addr or we_n or sel or bus) begin
		word = mem.exists(addr) ? mem[addr] : 16'h0000;
		if (!we_n && sel != 2'h0) begin
			if (sel[0])
				word[7:0] = bus[7:0];
			if (sel[1])
				word[15:8] = bus[15:8];
			mem[addr] = word;
		end
	end
endmodule : sbl_sram_model
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the SRAM host port.
// Memory model resolves the data bus; no other stimulus.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        SYS_CLK = 0, RST = 1, REQ_VALID = 0, REQ_WRITE = 0;
	logic        REQ_READY, RSP_VALID, cs_n, oe_n, we_n, lo_n, hi_n;
	logic [17:0] REQ_ADDR = 0, SRAM_ADDR;
	logic [15:0] REQ_WDATA = 0, RSP_RDATA, SRAM_DQ_I, SRAM_DQ_O, rd;
	logic [1:0]  REQ_BYTE_EN = 0, SRAM_DQ_OE;
	int          n_errors = 0, num_checks = 0, cyc = 0, cs_cnt = 0;
	sbl_sram_host DUT (.SYS_CLK(SYS_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
		.REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
		.REQ_WDATA(REQ_WDATA), .REQ_BYTE_EN(REQ_BYTE_EN),
		.RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .SRAM_ADDR(SRAM_ADDR),
		.SRAM_CS_N(cs_n), .SRAM_OE_N(oe_n), .SRAM_WE_N(we_n),
		.SRAM_LOW_BYTE_LANE_SEL_N(lo_n), .SRAM_HIGH_BYTE_LANE_SEL_N(hi_n),
		.SRAM_DQ_I(SRAM_DQ_I), .SRAM_DQ_O(SRAM_DQ_O), .SRAM_DQ_OE(SRAM_DQ_OE));
	sbl_sram_model mem_model (.addr(SRAM_ADDR), .cs_n(cs_n), .oe_n(oe_n),
		.we_n(we_n), .low_byte_lane_sel_n(lo_n), .high_byte_lane_sel_n(hi_n),
		.host_dq(SRAM_DQ_O), .host_oe(SRAM_DQ_OE), .bus(SRAM_DQ_I));
	initial forever #5 SYS_CLK = ~SYS_CLK;
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cs_n === 1'b0)
			cs_cnt++;
		if (cyc == 3000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [15:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One request, held until taken, then wait for its answer
	task automatic req(input logic w, input logic [17:0] a,
		input logic [15:0] d, input logic [1:0] be);
		int n;
		REQ_VALID = 1'b1;
		REQ_WRITE = w;
		REQ_ADDR = a;
		REQ_WDATA = d;
		REQ_BYTE_EN = be;
		for (n = 0; REQ_READY !== 1'b1 && n < 20; n++) begin
			@(posedge SYS_CLK);
			#1;
		end
		@(posedge SYS_CLK);
		#1;
		REQ_VALID = 1'b0;
		// Busy after a bus request, still idle after an empty one
		chk("ready after take", {15'h0000, be == 2'h0},
			{15'h0000, REQ_READY});
		for (n = 0; RSP_VALID !== 1'b1 && n < 20; n++) begin
			@(posedge SYS_CLK);
			#1;
		end
		chk("answer seen", 16'h0001, {15'h0000, RSP_VALID});
		rd = RSP_RDATA;
		@(posedge SYS_CLK);
		#1;
		chk("answer pulse", 16'h0000, {15'h0000, RSP_VALID});
	endtask : req
	task automatic s_full_word();
		req(1'b1, 18'h00123, 16'hA55A, 2'h3);
		req(1'b0, 18'h00123, 16'h0000, 2'h3);
		chk("full read", 16'hA55A, rd);
		req(1'b0, 18'h00123, 16'h0000, 2'h1);
		chk("low read", 16'h005A, rd);
		req(1'b0, 18'h00123, 16'h0000, 2'h2);
		chk("high read", 16'hA500, rd);
	endtask : s_full_word
	// Single-lane writes at both address ends keep the other byte
	task automatic s_byte_writes();
		logic [17:0] a;
		for (int i = 0; i < 2; i++) begin
			a = i ? 18'h3FFFF : 18'h00000;
			req(1'b1, a, 16'h1234, 2'h3);
			req(1'b1, a, 16'hFFCD, 2'h1);
			req(1'b0, a, 16'h0000, 2'h3);
			chk("low write", 16'h12CD, rd);
			req(1'b1, a, 16'hEF00, 2'h2);
			req(1'b0, a, 16'h0000, 2'h3);
			chk("high write", 16'hEFCD, rd);
		end
		req(1'b0, 18'h00123, 16'h0000, 2'h3);
		chk("other word", 16'hA55A, rd);
	endtask : s_byte_writes
	// Reset mid-run: pins idle, answer cleared, memory kept
	task automatic s_mid_reset();
		logic [15:0] p;
		RST = 1'b1;
		repeat (2) @(posedge SYS_CLK);
		#1;
		p = {9'h000, cs_n, oe_n, we_n, lo_n, hi_n, SRAM_DQ_OE};
		chk("reset pins", 16'h007C, p);
		chk("reset handshake", 16'h0002, {14'h0000, REQ_READY, RSP_VALID});
		chk("reset data", 16'h0000, RSP_RDATA);
		RST = 1'b0;
		req(1'b0, 18'h00123, 16'h0000, 2'h3);
		chk("kept word", 16'hA55A, rd);
	endtask : s_mid_reset
	// Empty requests open no bus cycle and leave the read data alone
	task automatic s_no_lanes();
		int c;
		c = cs_cnt;
		req(1'b1, 18'h00042, 16'hBEEF, 2'h0);
		req(1'b0, 18'h00123, 16'h0000, 2'h0);
		chk("no select", c[15:0], cs_cnt[15:0]);
		chk("no lane read", 16'hA55A, rd);
		req(1'b0, 18'h00042, 16'h0000, 2'h3);
		chk("no store", 16'h0000, rd);
	endtask : s_no_lanes
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (5) @(posedge SYS_CLK);
		#1;
		RST = 1'b0;
		s_full_word();
		s_byte_writes();
		s_mid_reset();
		s_no_lanes();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire

// File: hdl/sbl_sram_host.sv
// Host controller driving an asynchronous 16-bit SRAM with byte lanes.
// Assumes pin inputs synchronous to SYS_CLK and an external tristate
// resolving SRAM_DQ from SRAM_DQ_O and SRAM_DQ_OE.
`timescale 1ns/100ps
`default_nettype none
module sbl_sram_host
	import sbl_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	// Clock and reset
	input  wire logic          SYS_CLK,
	input  wire logic          RST,
	// Request from the user side
	input  wire logic          REQ_VALID,
	output logic               REQ_READY,
	input  wire logic          REQ_WRITE,
	input  wire logic [AW-1:0] REQ_ADDR,
	input  wire logic [DW-1:0] REQ_WDATA,
	input  wire logic [1:0]    REQ_BYTE_EN,
	// Answer to the user side
	output logic               RSP_VALID,
	output logic [DW-1:0]      RSP_RDATA,
	// Memory control pins
	output logic [AW-1:0]      SRAM_ADDR,
	output logic               SRAM_CS_N,
	output logic               SRAM_OE_N,
	output logic               SRAM_WE_N,
	output logic               SRAM_LOW_BYTE_LANE_SEL_N,
	output logic               SRAM_HIGH_BYTE_LANE_SEL_N,
	// Memory data pins, one enable per byte lane
	input  wire logic [DW-1:0] SRAM_DQ_I,
	output logic [DW-1:0]      SRAM_DQ_O,
	output logic [1:0]         SRAM_DQ_OE
);
	localparam int LW = DW / LANES;

	generate
		if (AW != ADDR_W || DW != DATA_W || LW != LANE_W) begin : g_bad
			$error("sbl_sram_host: bus widths do not match the memory");
		end
		if (RD_ACCESS_CYC >= (1 << TIMER_W)
			|| WR_PULSE_CYC >= (1 << TIMER_W)
			|| RD_FLOAT_CYC >= (1 << TIMER_W)) begin : g_bad_timer
			$error("sbl_sram_host: timer too narrow for wait counts");
		end
	endgenerate

	// Lane enables are active high on the user side, low at the pins
	function automatic logic [LANES-1:0] lanes_n(
		input logic [LANES-1:0] byte_en
	);
		lanes_n = ~byte_en;
	endfunction

	// Keep only the selected lanes of a word
	function automatic logic [DW-1:0] lane_mask(
		input logic [LANES-1:0] lane_n,
		input logic [DW-1:0]    word
	);
		logic [DW-1:0] m;
		m = word;
		if (lane_n[0]) begin
			m[LW-1:0] = '0;
		end
		if (lane_n[1]) begin
			m[DW-1:LW] = '0;
		end
		lane_mask = m;
	endfunction

	sbl_state_e          state_q;
	sbl_state_e          state_d;
	logic                timer_load;
	logic [TIMER_W-1:0]  timer_cycles;
	logic                timer_done;
	logic [AW-1:0]       addr_q;
	logic [DW-1:0]       wdata_q;
	logic [LANES-1:0]    lane_n_q;
	logic [LANES-1:0]    lane_n_d;
	logic                cs_n_q;
	logic                oe_n_q;
	logic                we_n_q;
	logic [LANES-1:0]    dq_oe_q;
	logic [DW-1:0]       rdata_q;
	logic                rsp_q;
	logic                take;
	logic                no_lane;

	assign REQ_READY = (state_q == ST_IDLE);
	assign take      = REQ_VALID && REQ_READY;
	// A request with no lane selected never opens a bus cycle
	assign no_lane   = (REQ_BYTE_EN == '0);
	assign lane_n_d  = lanes_n(REQ_BYTE_EN);

	sbl_wait_timer #(
		.W           (TIMER_W)
	) u_timer (
		.clk         (SYS_CLK),
		.rst         (RST),
		.load        (timer_load),
		.load_cycles (timer_cycles),
		.done        (timer_done)
	);

	// Sequencer next state and timer loads
	always_comb begin
		state_d      = state_q;
		timer_load   = 1'b0;
		timer_cycles = TIMER_W'(1);
		case (state_q)
			ST_IDLE: begin
				if (take && !no_lane) begin
					if (REQ_WRITE) begin
						state_d = ST_WR_SETUP;
					end else begin
						state_d      = ST_RD_ACC;
						timer_load   = 1'b1;
						timer_cycles = TIMER_W'(RD_ACCESS_CYC);
					end
				end
			end
			ST_RD_ACC: begin
				if (timer_done) begin
					state_d      = ST_RD_FLOAT;
					timer_load   = 1'b1;
					timer_cycles = TIMER_W'(RD_FLOAT_CYC);
				end
			end
			ST_RD_FLOAT: begin
				// Let the device release the bus before any write
				if (timer_done) begin
					state_d = ST_IDLE;
				end
			end
			ST_WR_SETUP: begin
				state_d      = ST_WR_PULSE;
				timer_load   = 1'b1;
				timer_cycles = TIMER_W'(WR_PULSE_CYC);
			end
			ST_WR_PULSE: begin
				if (timer_done) begin
					state_d = ST_WR_HOLD;
				end
			end
			ST_WR_HOLD: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Request capture; address and lanes stay put for the whole access
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			addr_q   <= ADDR_ZERO;
			wdata_q  <= DATA_ZERO;
			lane_n_q <= LANES_OFF;
		end else if (take) begin
			addr_q   <= REQ_ADDR;
			wdata_q  <= REQ_WDATA;
			lane_n_q <= lane_n_d;
		end
	end

	// Chip select low exactly over the bus phases
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			cs_n_q <= 1'b1;
		end else begin
			cs_n_q <= !(state_d == ST_RD_ACC || state_d == ST_WR_SETUP
				|| state_d == ST_WR_PULSE || state_d == ST_WR_HOLD);
		end
	end

	// Output drive only in read access, kept off during writes
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			oe_n_q <= 1'b1;
		end else begin
			oe_n_q <= (state_d != ST_RD_ACC);
		end
	end

	// Write strobe low only in the pulse phase, never in a read
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			we_n_q <= 1'b1;
		end else begin
			we_n_q <= (state_d != ST_WR_PULSE);
		end
	end

	// Data driven through the pulse and one cycle past strobe rise
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			dq_oe_q <= '0;
		end else if (state_d == ST_WR_PULSE || state_d == ST_WR_HOLD) begin
			dq_oe_q <= ~lane_n_q;
		end else begin
			dq_oe_q <= '0;
		end
	end

	// Read capture of the selected lanes only
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rdata_q <= DATA_ZERO;
		end else if (state_q == ST_RD_ACC && timer_done) begin
			rdata_q <= lane_mask(lane_n_q, SRAM_DQ_I);
		end
	end

	// One-cycle answer per request
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rsp_q <= 1'b0;
		end else begin
			rsp_q <= (state_q == ST_RD_ACC && timer_done)
				|| (state_q == ST_WR_HOLD)
				|| (take && no_lane);
		end
	end

	assign RSP_VALID                 = rsp_q;
	assign RSP_RDATA                 = rdata_q;
	assign SRAM_ADDR                 = addr_q;
	assign SRAM_CS_N                 = cs_n_q;
	assign SRAM_OE_N                 = oe_n_q;
	assign SRAM_WE_N                 = we_n_q;
	// Lanes follow select so they never outlast the access
	assign SRAM_LOW_BYTE_LANE_SEL_N  = lane_n_q[0] | cs_n_q;
	assign SRAM_HIGH_BYTE_LANE_SEL_N = lane_n_q[1] | cs_n_q;
	assign SRAM_DQ_O                 = wdata_q;
	assign SRAM_DQ_OE                = dq_oe_q;
endmodule : sbl_sram_host
`default_nettype wire

// File: hdl/sbl_wait_timer.sv
// Down-counting wait timer for the SRAM port sequencer.
// Assumes the loader keeps load high for one cycle per phase.
`timescale 1ns/100ps
`default_nettype none
module sbl_wait_timer #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] load_cycles,
	// Status
	output logic              done
);
	logic [W-1:0] cnt_q;

	generate
		if (W < 1) begin : g_bad_width
			$error("sbl_wait_timer: width must be at least one");
		end
	endgenerate

	// Phase lasts load_cycles cycles, done in its last one
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= load_cycles - W'(1);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

	assign done = (cnt_q == '0);
endmodule : sbl_wait_timer
`default_nettype wire

// File: shared/sbl_pkg.sv
// Constants for the host-side asynchronous SRAM byte-lane port.
// Assumes a 100 MHz system clock; all pin timing derives from it.
package sbl_pkg;
	localparam int ADDR_W        = 18;
	localparam int DATA_W        = 16;
	localparam int LANE_W        = 8;
	localparam int LANES         = 2;
	localparam int TIMER_W       = 4;

	// Clock period and device timing figures in ns, sample margin in cycles
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_AA_NS       = 10;
	localparam int T_PWE_NS      = 7;
	localparam int T_SD_NS       = 5;
	localparam int T_HZWE_NS     = 5;
	localparam int T_HZOE_NS     = 5;
	localparam int SAMPLE_MARGIN = 1;

	// Least times rounded up to whole cycles
	localparam int RD_ACCESS_CYC =
		(T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SAMPLE_MARGIN;
	localparam int PWE_CYC =
		(T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SD_HZ_CYC =
		(T_SD_NS + T_HZWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_PULSE_CYC =
		(PWE_CYC > SD_HZ_CYC) ? PWE_CYC : SD_HZ_CYC;
	localparam int RD_FLOAT_CYC =
		(T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [LANES-1:0]  LANES_OFF = 2'h3;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h00000;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_RD_ACC   = 3'b001,
		ST_RD_FLOAT = 3'b010,
		ST_WR_SETUP = 3'b011,
		ST_WR_PULSE = 3'b100,
		ST_WR_HOLD  = 3'b101
	} sbl_state_e;
endpackage : sbl_pkg
